// ===== core/fmcsr_regs.sv
// Fan duty, configuration and first limit status register bank
// Notes on behaviour
// - Diode fault forces temperature reading 0x80
// - Extended read freezes it and matching readings
// - Duty registers linear, reset to 0xFF
// - Automatic mode reports actual driving duty
// - Fan startup reads duty as 0x00
// - Software mode write sets duty directly
// - Start bit selects programmed or default limits
// - Lock makes start bit read-only
// - Lock bit write-once, locks lockable bits
// - Ready bit set after power up
// - Full-speed bit forces fans, never locked
// - Power-measure flag, lockable, software only
// - Spin-up bit holds PWM high full timeout
// - Bit 6 disables bus timeout
// - Bit 7 selects 5 V or 3.3 V scaling
// - Voltage flags clear on read if ended
// - Temperature flags clear on read if ended
// - Bit 7 is OR of second status
// - Config and status reset to 0x00
// - High is greater, low is less-or-equal
`timescale 1ns/1ns
module fmcsr_regs
    import fmcsr_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic auto_mode,
    input wire logic [7:0] auto_duty [0:2],
    input wire logic [2:0] fan_startup,
    input wire logic [7:0] volt_raw [0:3],
    input wire logic [7:0] temp_raw [0:2],
    input wire logic [2:0] diode_fault,
    input wire logic [7:0] ext_raw1,
    input wire logic [7:0] ext_raw2,
    input wire logic [7:0] second_status,
    input wire logic powered_up,
    output logic [7:0] fan_duty_out [0:2],
    output logic monitor_go,
    output logic force_full_fans,
    output logic spinup_pulse_disable,
    output logic bus_timeout_disable,
    output logic vcc_5v_scale
);
    fmcsr_bus_if bus ();

    logic [7:0] duty_ff [0:2];
    logic [7:0] cfg_ff;
    logic [6:0] sts_ff;
    logic [7:0] volt_ff [0:3];
    logic [7:0] temp_ff [0:2];
    logic [7:0] ext1_ff;
    logic [7:0] ext2_ff;
    logic [3:0] vfrz_ff;
    logic [2:0] tfrz_ff;
    logic [1:0] pwr_sync_ff;
    logic [7:0] rdy_cnt_ff;
    fmcsr_pwr_t pwr_state_ff;
    logic [7:0] rdata_ff;
    logic [7:0] duty_out_ff [0:2];
    logic [4:0] cfg_out_ff;

    wire cfg_wr = wr_stb && addr == ADDR_MAIN_CONFIG;
    wire sts_rd = rd_stb && addr == ADDR_LIMIT_STATUS;
    wire ext1_rd = rd_stb && addr == ADDR_EXT_RES1;
    wire ext2_rd = rd_stb && addr == ADDR_EXT_RES2;
    wire is_ready = pwr_state_ff == FMCSR_PWR_READY;

    // Merge of writable config bits under lock
    function automatic logic [7:0] cfg_next(input logic [7:0] cur, input logic [7:0] wd);
        logic [7:0] n;
        n = cur;
        n[CFG_FULL] = wd[CFG_FULL];
        n[CFG_SPIN] = wd[CFG_SPIN];
        if (!cur[CFG_LOCK]) begin
            n[CFG_GO] = wd[CFG_GO];
            n[CFG_VXI] = wd[CFG_VXI];
            n[CFG_BUS_TIMEOUT_DISABLE] = wd[CFG_BUS_TIMEOUT_DISABLE];
            n[CFG_VSCALE] = wd[CFG_VSCALE];
            n[CFG_LOCK] = wd[CFG_LOCK];
        end
        n[CFG_READY] = 1'b0;
        cfg_next = n;
    endfunction

    // Readback value of one duty register; inputs passed in so the mux re-evaluates
    function automatic logic [7:0] duty_view(input logic startup, input logic [7:0] duty);
        duty_view = startup ? DUTY_STARTUP : duty;
    endfunction

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_ff <= CONFIG_RESET;
        end else if (cfg_wr) begin
            cfg_ff <= cfg_next(cfg_ff, wdata);
        end
    end

    // Power-good pin is asynchronous; ready waits a short settle time
    always_ff @(posedge mclk) begin
        if (srst) begin
            pwr_sync_ff <= 2'b00;
            pwr_state_ff <= FMCSR_PWR_WAIT;
            rdy_cnt_ff <= 8'h00;
        end else begin
            pwr_sync_ff <= {pwr_sync_ff[0], powered_up};
            if (pwr_state_ff == FMCSR_PWR_WAIT && pwr_sync_ff[1]) begin
                if (rdy_cnt_ff == 8'(READY_CYCLES - 1)) begin
                    pwr_state_ff <= FMCSR_PWR_READY;
                end else begin
                    rdy_cnt_ff <= rdy_cnt_ff + 8'h01;
                end
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < NUM_FANS; g++) begin : g_fan
            wire duty_wr = wr_stb && addr == 8'(ADDR_FAN1_DUTY + g);
            always_ff @(posedge mclk) begin
                if (srst) begin
                    duty_ff[g] <= DUTY_RESET;
                end else if (!auto_mode && duty_wr) begin
                    duty_ff[g] <= wdata;
                end
            end
            wire [7:0] nxt_duty = cfg_ff[CFG_FULL] ? DUTY_FULL
                : auto_mode ? auto_duty[g] : duty_ff[g];
            always_ff @(posedge mclk) begin
                if (srst) begin
                    duty_out_ff[g] <= DUTY_RESET;
                end else begin
                    duty_out_ff[g] <= nxt_duty;
                end
            end
        end
        for (g = 0; g < NUM_VOLT; g++) begin : g_volt
            always_ff @(posedge mclk) begin
                if (srst) begin
                    volt_ff[g] <= 8'h00;
                    vfrz_ff[g] <= 1'b0;
                end else begin
                    if (ext1_rd) begin
                        vfrz_ff[g] <= 1'b1;
                    end else if (rd_stb && addr == 8'(ADDR_VOLT_BASE + g)) begin
                        vfrz_ff[g] <= 1'b0;
                    end
                    if (!vfrz_ff[g] && !ext1_rd) begin
                        volt_ff[g] <= volt_raw[g];
                    end
                end
            end
        end
        for (g = 0; g < NUM_TEMP; g++) begin : g_temp
            always_ff @(posedge mclk) begin
                if (srst) begin
                    temp_ff[g] <= TEMP_DIODE_FAULT;
                    tfrz_ff[g] <= 1'b0;
                end else begin
                    if (ext2_rd) begin
                        tfrz_ff[g] <= 1'b1;
                    end else if (rd_stb && addr == 8'(ADDR_TEMP_BASE + g)) begin
                        tfrz_ff[g] <= 1'b0;
                    end
                    if (!tfrz_ff[g] && !ext2_rd) begin
                        temp_ff[g] <= diode_fault[g] ? TEMP_DIODE_FAULT : temp_raw[g];
                    end
                end
            end
        end
    endgenerate

    // Extended registers stay frozen until all their readings are read
    always_ff @(posedge mclk) begin
        if (srst) begin
            ext1_ff <= 8'h00;
            ext2_ff <= 8'h00;
        end else begin
            if (vfrz_ff == 4'h0 && !ext1_rd) begin
                ext1_ff <= ext_raw1;
            end
            if (tfrz_ff == 3'h0 && !ext2_rd) begin
                ext2_ff <= ext_raw2;
            end
        end
    end

    assign bus.addr = addr;
    assign bus.wdata = wdata;
    assign bus.wr_stb = wr_stb;
    assign bus.go = cfg_ff[CFG_GO];
    generate
        for (g = 0; g < NUM_VOLT; g++) begin : g_bv
            assign bus.reading[g] = volt_ff[g];
        end
        for (g = 0; g < NUM_TEMP; g++) begin : g_bt
            assign bus.reading[NUM_VOLT + g] = temp_ff[g];
        end
    endgenerate

    fmcsr_limit_cmp u_cmp (
        .mclk(mclk),
        .srst(srst),
        .bus(bus)
    );

    // Monitoring only once ready; set wins over the read clear
    wire [6:0] events = (is_ready && cfg_ff[CFG_GO]) ? bus.out_of_limit : 7'h00;
    wire [6:0] nxt_sts = events | (sts_rd ? (sts_ff & bus.out_of_limit) : sts_ff);
    always_ff @(posedge mclk) begin
        if (srst) begin
            sts_ff <= 7'h00;
        end else begin
            sts_ff <= nxt_sts;
        end
    end

    wire [7:0] cfg_view = {cfg_ff[7:3], is_ready, cfg_ff[1:0]};
    wire [7:0] sts_view = {|second_status, sts_ff};
    wire [7:0] nxt_rdata =
        (addr == ADDR_FAN1_DUTY) ? duty_view(fan_startup[0], duty_out_ff[0]) :
        (addr == ADDR_FAN2_DUTY) ? duty_view(fan_startup[1], duty_out_ff[1]) :
        (addr == ADDR_FAN3_DUTY) ? duty_view(fan_startup[2], duty_out_ff[2]) :
        (addr == ADDR_MAIN_CONFIG) ? cfg_view :
        (addr == ADDR_LIMIT_STATUS) ? sts_view :
        (addr == ADDR_EXT_RES1) ? ext1_ff :
        (addr == ADDR_EXT_RES2) ? ext2_ff :
        (addr >= ADDR_VOLT_BASE && addr < ADDR_TEMP_BASE && addr != 8'h24)
            ? volt_ff[2'(addr - ADDR_VOLT_BASE)] :
        (addr >= ADDR_TEMP_BASE && addr < 8'h28) ? temp_ff[2'(addr - ADDR_TEMP_BASE)] :
        UNMAPPED_READ;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
            cfg_out_ff <= 5'h00;
        end else begin
            rdata_ff <= rd_stb ? nxt_rdata : 8'h00;
            cfg_out_ff <= {cfg_ff[CFG_GO], cfg_ff[CFG_FULL], cfg_ff[CFG_SPIN],
                cfg_ff[CFG_BUS_TIMEOUT_DISABLE], cfg_ff[CFG_VSCALE]};
        end
    end

    assign rdata = rdata_ff;
    assign fan_duty_out = duty_out_ff;
    assign monitor_go = cfg_out_ff[4];
    assign force_full_fans = cfg_out_ff[3];
    assign spinup_pulse_disable = cfg_out_ff[2];
    assign bus_timeout_disable = cfg_out_ff[1];
    assign vcc_5v_scale = cfg_out_ff[0];
endmodule // fmcsr_regs

// ===== core/fmcsr_pkg.sv
// Constants and types shared by the fan monitor register bank
package fmcsr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_FANS = 3;
    localparam int NUM_VOLT = 4;
    localparam int NUM_TEMP = 3;
    localparam logic [7:0] ADDR_FAN1_DUTY = 8'h30;
    localparam logic [7:0] ADDR_FAN2_DUTY = 8'h31;
    localparam logic [7:0] ADDR_FAN3_DUTY = 8'h32;
    localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h40;
    localparam logic [7:0] ADDR_LIMIT_STATUS = 8'h41;
    localparam logic [7:0] ADDR_EXT_RES1 = 8'h76;
    localparam logic [7:0] ADDR_EXT_RES2 = 8'h77;
    localparam logic [7:0] ADDR_VOLT_BASE = 8'h20;
    localparam logic [7:0] ADDR_TEMP_BASE = 8'h25;
    localparam logic [7:0] ADDR_LIMIT_BASE = 8'h44;
    localparam logic [7:0] ADDR_LIMIT_LAST = 8'h53;
    localparam logic [7:0] DUTY_RESET = 8'hFF;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_STARTUP = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] TEMP_DIODE_FAULT = 8'h80;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int CFG_GO = 0;
    localparam int CFG_LOCK = 1;
    localparam int CFG_READY = 2;
    localparam int CFG_FULL = 3;
    localparam int CFG_VXI = 4;
    localparam int CFG_SPIN = 5;
    localparam int CFG_BUS_TIMEOUT_DISABLE = 6;
    localparam int CFG_VSCALE = 7;
    localparam int STS_ANY2 = 7;
    localparam logic [7:0] VOLT_LOW_DEF = 8'h00;
    localparam logic [7:0] VOLT_HIGH_DEF = 8'hFF;
    localparam logic [7:0] TEMP_LOW_DEF = 8'h81;
    localparam logic [7:0] TEMP_HIGH_DEF = 8'h7F;
    localparam int READY_DELAY_US = 1;
    localparam int CLK_MHZ = 25;
    localparam int READY_CYCLES = READY_DELAY_US * CLK_MHZ;
    typedef enum logic [1:0] {
        FMCSR_PWR_WAIT = 2'b00,
        FMCSR_PWR_READY = 2'b01
    } fmcsr_pwr_t;
endpackage

// ===== core/fmcsr_bus_if.sv
// Register access signals passed to the limit comparator
`timescale 1ns/1ns
interface fmcsr_bus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic go;
    logic [7:0] reading [0:6];
    logic [6:0] out_of_limit;
    modport bank (output addr, output wdata, output wr_stb, output go, output reading,
        input out_of_limit);
    modport cmp (input addr, input wdata, input wr_stb, input go, input reading,
        output out_of_limit);
endinterface

// ===== core/fmcsr_limit_cmp.sv
// Limit registers and window comparators for voltage and temperature readings
`timescale 1ns/1ns
module fmcsr_limit_cmp
    import fmcsr_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    fmcsr_bus_if.cmp bus
);
    logic [7:0] low_ff [0:6];
    logic [7:0] high_ff [0:6];

    // Signed compare for temperatures, unsigned for voltages
    function automatic logic outside(input logic [7:0] v, input logic [7:0] lo,
        input logic [7:0] hi, input logic sgn);
        if (sgn) begin
            outside = ($signed(v) > $signed(hi)) || ($signed(v) <= $signed(lo));
        end else begin
            outside = (v > hi) || (v <= lo);
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_ch
            localparam logic [7:0] LO_DEF = (g < NUM_VOLT) ? VOLT_LOW_DEF : TEMP_LOW_DEF;
            localparam logic [7:0] HI_DEF = (g < NUM_VOLT) ? VOLT_HIGH_DEF : TEMP_HIGH_DEF;
            // Index 4 is the 12 V pair, skipped in this bank; temps start at 0x4E
            localparam logic [7:0] LA = (g < NUM_VOLT) ? 8'(ADDR_LIMIT_BASE + 2 * g)
                : 8'(8'h4E + 2 * (g - NUM_VOLT));
            wire [7:0] use_lo = bus.go ? low_ff[g] : LO_DEF;
            wire [7:0] use_hi = bus.go ? high_ff[g] : HI_DEF;
            always_ff @(posedge mclk) begin
                if (srst) begin
                    low_ff[g] <= LO_DEF;
                    high_ff[g] <= HI_DEF;
                end else if (bus.wr_stb && bus.addr == LA) begin
                    low_ff[g] <= bus.wdata;
                end else if (bus.wr_stb && bus.addr == 8'(LA + 8'h01)) begin
                    high_ff[g] <= bus.wdata;
                end
            end
            assign bus.out_of_limit[g] = outside(bus.reading[g], use_lo, use_hi,
                g >= NUM_VOLT);
        end
    endgenerate
endmodule // fmcsr_limit_cmp

// ===== tb/fmcsr_host_model.sv
// Host bus controller model for the register port
`timescale 1ns/1ns
module fmcsr_host_model (
    input wire logic mclk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'h0;
        rd_stb = 1'h0;
    end
    // Released lines carry the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge mclk);
        wr_stb <= 1'h0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge mclk);
        rd_stb <= 1'h0;
        addr <= ~a;
        #1;
        q = rdata;
    endtask
endmodule // fmcsr_host_model

// ===== tb/fmcsr_monitor.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module fmcsr_monitor
    import fmcsr_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic auto_mode,
    input wire logic [2:0] fan_startup,
    input wire logic [2:0] diode_fault,
    input wire logic [7:0] second_status,
    input wire logic [7:0] fan_duty_out [0:2],
    input wire logic monitor_go,
    input wire logic force_full_fans,
    input wire logic bus_timeout_disable,
    input wire logic vcc_5v_scale
);
    logic lock_ff;
    wire cfg_wr = wr_stb && addr == ADDR_MAIN_CONFIG;
    wire all_full = (fan_duty_out[0] & fan_duty_out[1] & fan_duty_out[2]) == DUTY_FULL;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Lock is internal, so it is rebuilt from the write that sets it
    always_ff @(posedge mclk) begin
        lock_ff <= srst ? 1'h0 : (lock_ff | (cfg_wr && wdata[CFG_LOCK]));
    end
    a_reset_values: assert property (
        disable iff (1'h0) srst |=> all_full && !monitor_go && !force_full_fans)
        else $error("outputs wrong after reset");
    a_sw_duty_write: assert property (
        wr_stb && addr == ADDR_FAN1_DUTY && !auto_mode && !force_full_fans && !fan_startup[0]
        |-> ##2 (force_full_fans || fan_duty_out[0] == $past(wdata, 2))) else $error("duty write lost");
    a_full_speed: assert property (
        force_full_fans && $past(force_full_fans) |-> all_full) else $error("fans not at full");
    a_full_unlocked: assert property (
        lock_ff && cfg_wr |-> ##2 force_full_fans == $past(wdata[CFG_FULL], 2))
        else $error("full speed bit locked");
    a_locked_bits: assert property (
        lock_ff && $past(lock_ff, 2) |-> $stable(monitor_go) && $stable(bus_timeout_disable)
        && $stable(vcc_5v_scale)) else $error("locked bit changed");
    a_status_or: assert property (
        rd_stb && addr == ADDR_LIMIT_STATUS && $stable(second_status)
        |=> rdata[STS_ANY2] == |$past(second_status, 2)) else $error("status bit 7 wrong");
    a_startup_read: assert property (
        rd_stb && addr == ADDR_FAN2_DUTY && fan_startup[1] && $past(fan_startup[1])
        |=> rdata == DUTY_STARTUP) else $error("startup duty not zero");
    a_diode_read: assert property (
        rd_stb && addr == 8'h26 && diode_fault[1] && $past(diode_fault[1], 3)
        |=> rdata == TEMP_DIODE_FAULT) else $error("diode fault code missing");
endmodule // fmcsr_monitor
bind fmcsr_regs fmcsr_monitor MON (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .auto_mode(auto_mode),
    .fan_startup(fan_startup), .diode_fault(diode_fault), .second_status(second_status),
    .fan_duty_out(fan_duty_out), .monitor_go(monitor_go), .force_full_fans(force_full_fans),
    .bus_timeout_disable(bus_timeout_disable), .vcc_5v_scale(vcc_5v_scale));

// ===== tb/testbench.sv
// Self-checking testbench for the fan monitor register bank
`timescale 1ns/1ns
module testbench
    import fmcsr_pkg::*;
;
    logic mclk = 1'h0, srst = 1'h1, auto_mode = 1'h0, powered_up = 1'h0;
    logic [2:0] fan_startup = 3'h0, diode_fault = 3'h0;
    logic [7:0] ext_raw1 = 8'h00, ext_raw2 = 8'h00, second_status = 8'h00;
    logic [7:0] auto_duty [0:2] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] temp_raw [0:2] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] volt_raw [0:3] = '{8'h80, 8'h80, 8'h80, 8'h80};
    logic [7:0] addr, wdata, rdata, q;
    logic [7:0] fan_duty_out [0:2];
    logic wr_stb, rd_stb, monitor_go, force_full_fans, spin_off, bus_to_off, vcc5;
    int err_total = 0, total_checks = 0;
    always #20 mclk = ~mclk;
    fmcsr_host_model HOST (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata));
    fmcsr_regs DUT (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .auto_mode(auto_mode), .auto_duty(auto_duty),
        .fan_startup(fan_startup), .volt_raw(volt_raw), .temp_raw(temp_raw),
        .diode_fault(diode_fault), .ext_raw1(ext_raw1), .ext_raw2(ext_raw2),
        .second_status(second_status), .powered_up(powered_up), .fan_duty_out(fan_duty_out),
        .monitor_go(monitor_go), .force_full_fans(force_full_fans),
        .spinup_pulse_disable(spin_off), .bus_timeout_disable(bus_to_off), .vcc_5v_scale(vcc5));
    // Ends 1 ns past the edge so sampled outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        HOST.rd(a, q);
        chk8($sformatf("reg %h", a), e, q);
    endtask
    task automatic test_done;
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 3; i++) begin
            rdc(ADDR_FAN1_DUTY + i[7:0], 8'hFF);
        end
        rdc(ADDR_MAIN_CONFIG, 8'h00);
        rdc(ADDR_LIMIT_STATUS, 8'h00);
    endtask
    task automatic t_ready;
        powered_up <= 1'h1;
        tick(5);
        rdc(ADDR_MAIN_CONFIG, 8'h00);
        tick(30);
        rdc(ADDR_MAIN_CONFIG, 8'h04);
    endtask
    task automatic t_sw;
        for (int i = 0; i < 3; i++) begin
            HOST.wr(ADDR_FAN1_DUTY + i[7:0], i[7:0] * 8'h7F);
        end
        tick(2);
        for (int i = 0; i < 3; i++) begin
            chk8("duty out", i[7:0] * 8'h7F, fan_duty_out[i]);
            rdc(ADDR_FAN1_DUTY + i[7:0], i[7:0] * 8'h7F);
        end
    endtask
    task automatic t_auto;
        auto_mode <= 1'h1;
        auto_duty <= '{8'h11, 8'h22, 8'h33};
        fan_startup <= 3'h2;
        tick(4);
        chk8("duty out", 8'h11, fan_duty_out[0]);
        rdc(ADDR_FAN2_DUTY, 8'h00);
        HOST.wr(ADDR_FAN1_DUTY, 8'h5A);
        tick(2);
        rdc(ADDR_FAN1_DUTY, 8'h11);
        rdc(ADDR_FAN3_DUTY, 8'h33);
        auto_mode <= 1'h0;
        fan_startup <= 3'h0;
    endtask
    task automatic t_status;
        volt_raw[0] <= 8'h10;
        temp_raw[0] <= 8'h21;
        HOST.wr(8'h44, 8'h10);
        HOST.wr(8'h4F, 8'h20);
        HOST.wr(ADDR_MAIN_CONFIG, 8'h01);
        second_status <= 8'h04;
        tick(4);
        rdc(ADDR_LIMIT_STATUS, 8'h91);
        rdc(ADDR_LIMIT_STATUS, 8'h91);
        volt_raw[0] <= 8'h11;
        temp_raw[0] <= 8'h20;
        second_status <= 8'h00;
        tick(4);
        rdc(ADDR_LIMIT_STATUS, 8'h11);
        rdc(ADDR_LIMIT_STATUS, 8'h00);
        HOST.wr(ADDR_MAIN_CONFIG, 8'h00);
        volt_raw[0] <= 8'h10;
        tick(4);
        rdc(ADDR_LIMIT_STATUS, 8'h00);
        // Programmed low limit must survive the stop and restart
        HOST.wr(ADDR_MAIN_CONFIG, 8'h01);
        tick(4);
        rdc(ADDR_LIMIT_STATUS, 8'h01);
        volt_raw[0] <= 8'h11;
    endtask
    task automatic t_freeze;
        volt_raw[1] <= 8'h55;
        temp_raw[2] <= 8'h19;
        ext_raw1 <= 8'h3C;
        ext_raw2 <= 8'hA5;
        diode_fault <= 3'h2;
        tick(4);
        rdc(ADDR_EXT_RES1, 8'h3C);
        rdc(ADDR_EXT_RES2, 8'hA5);
        volt_raw[1] <= 8'h66;
        temp_raw[2] <= 8'h1A;
        ext_raw1 <= 8'h3D;
        tick(4);
        rdc(8'h21, 8'h55);
        rdc(8'h27, 8'h19);
        tick(3);
        rdc(8'h21, 8'h66);
        rdc(8'h27, 8'h1A);
        rdc(ADDR_EXT_RES1, 8'h3C);
        rdc(8'h26, 8'h80);
        diode_fault <= 3'h0;
    endtask
    task automatic t_lock;
        HOST.wr(ADDR_MAIN_CONFIG, 8'hF1);
        tick(2);
        chk8("cfg outs", 8'h0F, {4'h0, monitor_go, spin_off, bus_to_off, vcc5});
        rdc(ADDR_MAIN_CONFIG, 8'hF5);
        HOST.wr(ADDR_MAIN_CONFIG, 8'hF3);
        HOST.wr(ADDR_MAIN_CONFIG, 8'h08);
        tick(2);
        rdc(ADDR_MAIN_CONFIG, 8'hDF);
        chk8("full outs", 8'h02, {6'h00, force_full_fans, spin_off});
        chk8("duty full", 8'hFF, fan_duty_out[0] & fan_duty_out[1] & fan_duty_out[2]);
        HOST.wr(ADDR_MAIN_CONFIG, 8'h00);
        rdc(ADDR_MAIN_CONFIG, 8'hD7);
        srst <= 1'h1;
        tick(2);
        srst <= 1'h0;
        rdc(ADDR_MAIN_CONFIG, 8'h00);
        rdc(ADDR_FAN1_DUTY, 8'hFF);
    endtask
    initial begin
        tick(4);
        srst <= 1'h0;
        t_reset();
        t_ready();
        t_sw();
        t_auto();
        t_status();
        t_freeze();
        t_lock();
        test_done();
    end
    // Whole sequence needs under two hundred cycles
    initial begin
        tick(5000);
        err_total++;
        test_done();
    end
endmodule // testbench
